// ### verilog/adcc_pkg.sv
// package: register map, field layout, timing and carrier types of the converter control
`default_nettype none
package adcc_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [8:0] ADCC_OFS_RESULT_HIGH = 9'h01e;
    localparam logic [8:0] ADCC_OFS_CONTROL = 9'h01f;
    localparam logic [8:0] ADCC_OFS_RESULT_LOW = 9'h09e;
    localparam logic [8:0] ADCC_OFS_CLOCK_CFG = 9'h09f;
    localparam logic [8:0] ADCC_OFS_ANALOG_SELECT_LOW_LOW = 9'h11e;
    localparam logic [8:0] ADCC_OFS_ANALOG_SELECT_LOW_HIGH = 9'h11f;
    localparam logic [8:0] ADCC_OFS_IRQ_STATUS = 9'h00c;
    localparam logic [8:0] ADCC_OFS_IRQ_ENABLE = 9'h08c;
    localparam logic [8:0] ADCC_OFS_IRQ_CLEAR = 9'h10c;
    // ****************************************
    // field positions
    // ****************************************
    localparam int ADCC_BIT_JUSTIFY = 7;
    localparam int ADCC_BIT_REFSEL = 6;
    localparam int ADCC_BIT_CHAN_HI = 5;
    localparam int ADCC_BIT_CHAN_LO = 2;
    localparam int ADCC_BIT_GO = 1;
    localparam int ADCC_BIT_ON = 0;
    localparam int ADCC_BIT_CLK_HI = 6;
    localparam int ADCC_BIT_CLK_LO = 4;
    localparam int ADCC_BIT_EV_DONE = 0;
    localparam int ADCC_BIT_EV_ABORT = 1;
    // ****************************************
    // reset values and fixed constants
    // ****************************************
    localparam logic [7:0] ADCC_RST_CONTROL = 8'h00;
    localparam logic [7:0] ADCC_RST_CLOCK_CFG = 8'h00;
    localparam logic [7:0] ADCC_RST_ANALOG_SELECT_LOW_LOW = 8'hff;
    localparam logic [3:0] ADCC_RST_ANALOG_SELECT_LOW_HIGH = 4'hf;
    localparam logic [1:0] ADCC_RST_EVENTS = 2'h0;
    localparam logic [3:0] ADCC_TRIG_MODE = 4'hb;
    localparam logic [12:0] ADCC_IRQ_VECTOR = 13'h0004;
    localparam int ADCC_RES_BITS = 10;
    // ****************************************
    // timing: one instruction cycle before an rc-clocked start
    // ****************************************
    localparam int ADCC_CLK_PERIOD_NS = 50;
    localparam int ADCC_INSTR_NS = 200;
    localparam logic [2:0] ADCC_INSTR_CLKS =
        3'((ADCC_INSTR_NS + ADCC_CLK_PERIOD_NS - 1) / ADCC_CLK_PERIOD_NS);
    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcc_bus_req_t;
    typedef struct packed {
        logic powered;
        logic sample;
        logic reference_select;
        logic [3:0] channel;
        logic [9:0] trial_code;
    } adcc_analog_t;
    typedef enum logic [1:0] {
        ADCC_ST_IDLE = 2'b00,
        ADCC_ST_DELAY = 2'b01,
        ADCC_ST_SAMPLE = 2'b10,
        ADCC_ST_CONVERT = 2'b11
    } adcc_state_t;
endpackage
`default_nettype wire

// ### verilog/adcc_conversion_control.sv
// module: sequencing, registers and interrupt logic of the 10-bit converter
`default_nettype none
module adcc_conversion_control
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire adcc_pkg::adcc_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // core and compare unit
    input wire logic sleep_active,
    input wire logic global_irq_enable,
    input wire logic peripheral_irq_enable,
    input wire logic [3:0] compare_mode_select,
    input wire logic compare_trigger,
    output logic timer_one_clear,
    output logic wake_request,
    output logic vector_jump,
    output logic [12:0] vector_addr,
    output logic irq,
    // analog side and pins
    input wire logic comparator_in,
    input wire logic rc_clock_in,
    output adcc_pkg::adcc_analog_t analog_ctl,
    output logic [11:0] analog_select
);
    import adcc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    adcc_state_t state_r, state_nxt;
    logic [7:0] control_r, control_nxt;
    logic [2:0] clk_sel_r;
    logic [7:0] analog_select_low_low_r;
    logic [3:0] analog_select_low_high_r;
    logic [7:0] result_high_r, result_low_r;
    logic [1:0] events_r, irq_en_r;
    logic pwr_off_r, pwr_off_nxt;
    logic [9:0] sar_r, sar_nxt;
    logic [3:0] bit_idx_r, bit_idx_nxt;
    logic [5:0] div_r;
    logic [2:0] delay_r;
    logic sleep_q_r;
    logic [7:0] rdata_r;
    logic rc_s1_r, rc_s2_r, rc_s3_r;
    logic wake_r, vector_r, tclr_r;

    // ****************************************
    // decode
    // ****************************************
    wire wr_control = bus_req.wr && bus_req.addr == ADCC_OFS_CONTROL;
    wire wr_clock = bus_req.wr && bus_req.addr == ADCC_OFS_CLOCK_CFG;
    wire wr_analog_select_low_lo = bus_req.wr && bus_req.addr == ADCC_OFS_ANALOG_SELECT_LOW_LOW;
    wire wr_analog_select_low_hi = bus_req.wr && bus_req.addr == ADCC_OFS_ANALOG_SELECT_LOW_HIGH;
    wire wr_irq_en = bus_req.wr && bus_req.addr == ADCC_OFS_IRQ_ENABLE;
    wire wr_irq_clr = bus_req.wr && bus_req.addr == ADCC_OFS_IRQ_CLEAR;
    wire conv_on = control_r[ADCC_BIT_ON];
    wire busy = state_r != ADCC_ST_IDLE;
    wire rc_selected = clk_sel_r[1:0] == 2'b11;
    wire sleep_rise = sleep_active && !sleep_q_r;
    wire trig_match = compare_trigger && compare_mode_select == ADCC_TRIG_MODE;
    // software go only counts with converter on in the same write
    wire sw_start = wr_control && bus_req.wdata[ADCC_BIT_GO] && bus_req.wdata[ADCC_BIT_ON];
    wire hw_start = trig_match && conv_on;
    wire start = !busy && (sw_start || hw_start) && !(sleep_active && !rc_selected);
    // software dropping go or on while busy stops the conversion
    wire sw_abort = busy && wr_control &&
                    (!bus_req.wdata[ADCC_BIT_GO] || !bus_req.wdata[ADCC_BIT_ON]);
    wire sleep_abort = busy && sleep_active && !rc_selected;
    wire abort = sw_abort || sleep_abort;

    // ****************************************
    // bit period tick
    // ****************************************
    // divide ratios per clock code
    logic [5:0] div_last;
    always_comb begin
        unique case (clk_sel_r)
            3'h0: div_last = 6'd1;
            3'h1: div_last = 6'd7;
            3'h2: div_last = 6'd31;
            3'h4: div_last = 6'd3;
            3'h5: div_last = 6'd15;
            3'h6: div_last = 6'd63;
            default: div_last = 6'd63;
        endcase
    end
    wire rc_edge = rc_s2_r && !rc_s3_r;
    wire div_tick = div_r == div_last;
    wire tad_tick = rc_selected ? rc_edge : div_tick;

    // ****************************************
    // sequencer
    // ****************************************
    wire finish = state_r == ADCC_ST_CONVERT && tad_tick && bit_idx_r == 4'h0 && !abort;
    wire [9:0] bit_mask = 10'(10'h001 << bit_idx_r);
    always_comb begin
        state_nxt = state_r;
        sar_nxt = sar_r;
        bit_idx_nxt = bit_idx_r;
        unique case (state_r)
            ADCC_ST_IDLE: begin
                // rc clock start held one instruction cycle
                if (start) begin
                    state_nxt = rc_selected ? ADCC_ST_DELAY : ADCC_ST_SAMPLE;
                end
            end
            ADCC_ST_DELAY: begin
                if (delay_r == 3'h1) begin
                    state_nxt = ADCC_ST_SAMPLE;
                end
            end
            ADCC_ST_SAMPLE: begin
                // ten trial bits from msb down
                if (tad_tick) begin
                    state_nxt = ADCC_ST_CONVERT;
                    sar_nxt = 10'h200;
                    bit_idx_nxt = 4'h9;
                end
            end
            ADCC_ST_CONVERT: begin
                if (tad_tick) begin
                    // comparator follows our own trial code; syncing it costs the /2 period
                    if (!comparator_in) begin
                        sar_nxt = sar_r & ~bit_mask;
                    end
                    if (bit_idx_r == 4'h0) begin
                        state_nxt = ADCC_ST_IDLE;
                    end else begin
                        sar_nxt = (comparator_in ? sar_r : sar_r & ~bit_mask) | (bit_mask >> 1);
                        bit_idx_nxt = bit_idx_r - 4'h1;
                    end
                end
            end
        endcase
        if (abort) begin
            state_nxt = ADCC_ST_IDLE;
        end
    end
    wire [9:0] final_code = comparator_in ? sar_r : (sar_r & ~bit_mask);

    // ****************************************
    // control register and power
    // ****************************************
    wire irq_path_on = irq_en_r[ADCC_BIT_EV_DONE] && peripheral_irq_enable;
    always_comb begin
        control_nxt = control_r;
        if (wr_control) begin
            control_nxt = bus_req.wdata;
            // go is set on a write only if that cycle starts a conversion, by software go or by a trigger
            control_nxt[ADCC_BIT_GO] = busy ? control_r[ADCC_BIT_GO] && !sw_abort : start;
        end else if (start) begin
            control_nxt[ADCC_BIT_GO] = 1'b1;
        end
        // go clears on finish or abort only
        if (finish || abort) begin
            control_nxt[ADCC_BIT_GO] = 1'b0;
        end
        pwr_off_nxt = pwr_off_r;
        if (wr_control) begin
            pwr_off_nxt = 1'b0;
        end
        // non-rc sleep powers off, on bit kept
        if (sleep_rise && !rc_selected) begin
            pwr_off_nxt = 1'b1;
        end
        // unattended completion in sleep powers off
        if (finish && sleep_active && !irq_path_on) begin
            pwr_off_nxt = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        rc_s1_r <= rc_clock_in;
        rc_s2_r <= rc_s1_r;
        rc_s3_r <= rc_s2_r;
    end

    // justify picks the split of the ten bits
    always_ff @(posedge clk_sys) begin
        if (finish) begin
            result_high_r <= control_r[ADCC_BIT_JUSTIFY] ? {6'h00, final_code[9:8]}
                                                         : final_code[9:2];
            result_low_r <= control_r[ADCC_BIT_JUSTIFY] ? final_code[7:0]
                                                        : {final_code[1:0], 6'h00};
        end
    end

    // every control register returns to its reset value
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= ADCC_ST_IDLE;
            control_r <= ADCC_RST_CONTROL;
            clk_sel_r <= ADCC_RST_CLOCK_CFG[ADCC_BIT_CLK_HI:ADCC_BIT_CLK_LO];
            analog_select_low_low_r <= ADCC_RST_ANALOG_SELECT_LOW_LOW;
            analog_select_low_high_r <= ADCC_RST_ANALOG_SELECT_LOW_HIGH;
            irq_en_r <= ADCC_RST_EVENTS;
            pwr_off_r <= 1'b0;
            sar_r <= 10'h000;
            bit_idx_r <= 4'h0;
            sleep_q_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            control_r <= control_nxt;
            pwr_off_r <= pwr_off_nxt;
            sar_r <= sar_nxt;
            bit_idx_r <= bit_idx_nxt;
            sleep_q_r <= sleep_active;
            // bits 6:4 hold the clock code
            if (wr_clock) begin
                clk_sel_r <= bus_req.wdata[ADCC_BIT_CLK_HI:ADCC_BIT_CLK_LO];
            end
            if (wr_analog_select_low_lo) begin
                analog_select_low_low_r <= bus_req.wdata;
            end
            if (wr_analog_select_low_hi) begin
                analog_select_low_high_r <= bus_req.wdata[3:0];
            end
            if (wr_irq_en) begin
                irq_en_r <= bus_req.wdata[1:0];
            end
        end
    end

    // divider restarts with each conversion so the first bit period is whole
    always_ff @(posedge clk_sys) begin
        if (!rstn || start || div_tick) begin
            div_r <= 6'h00;
        end else begin
            div_r <= div_r + 6'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            delay_r <= 3'h0;
        end else if (start) begin
            delay_r <= ADCC_INSTR_CLKS;
        end else if (delay_r != 3'h0) begin
            delay_r <= delay_r - 3'h1;
        end
    end

    // ****************************************
    // events and interrupt
    // ****************************************
    wire [1:0] ev_set = {abort, finish};
    wire [1:0] ev_clr = wr_irq_clr ? bus_req.wdata[1:0] : 2'h0;
    // sticky done and abort flags; a set beats a clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            events_r <= ADCC_RST_EVENTS;
        end else begin
            events_r <= (events_r & ~ev_clr) | ev_set;
        end
    end
    assign irq = |(events_r & irq_en_r);

    // wake and vector choice on completion in sleep
    // timer clear on any matching trigger
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wake_r <= 1'b0;
            vector_r <= 1'b0;
            tclr_r <= 1'b0;
        end else begin
            wake_r <= finish && sleep_active && irq_path_on;
            vector_r <= finish && sleep_active && irq_path_on && global_irq_enable;
            tclr_r <= trig_match;
        end
    end
    assign wake_request = wake_r;
    assign vector_jump = vector_r;
    assign vector_addr = ADCC_IRQ_VECTOR;
    assign timer_one_clear = tclr_r;

    // ****************************************
    // read port
    // ****************************************
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus_req.addr)
            ADCC_OFS_RESULT_HIGH: rd_mux = result_high_r;
            ADCC_OFS_CONTROL: rd_mux = control_r;
            ADCC_OFS_RESULT_LOW: rd_mux = result_low_r;
            ADCC_OFS_CLOCK_CFG: rd_mux = {1'b0, clk_sel_r, 4'h0};
            ADCC_OFS_ANALOG_SELECT_LOW_LOW: rd_mux = analog_select_low_low_r;
            ADCC_OFS_ANALOG_SELECT_LOW_HIGH: rd_mux = {4'h0, analog_select_low_high_r};
            ADCC_OFS_IRQ_STATUS: rd_mux = {6'h00, events_r};
            ADCC_OFS_IRQ_ENABLE: rd_mux = {6'h00, irq_en_r};
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= bus_req.rd ? rd_mux : 8'h00;
        end
    end
    assign bus_rdata = rdata_r;

    // ****************************************
    // analog side
    // ****************************************
    // module powered only while on and not shut by sleep
    assign analog_ctl.powered = conv_on && !pwr_off_r;
    assign analog_ctl.sample = state_r == ADCC_ST_SAMPLE || !busy;
    assign analog_ctl.reference_select = control_r[ADCC_BIT_REFSEL];
    assign analog_ctl.channel = control_r[ADCC_BIT_CHAN_HI:ADCC_BIT_CHAN_LO];
    assign analog_ctl.trial_code = sar_r;
    assign analog_select = {analog_select_low_high_r, analog_select_low_low_r};

    // ****************************************
    // assertions
    // ****************************************
    AST_GO_TRACKS_BUSY: assert property (@(posedge clk_sys) disable iff (!rstn)
        control_r[ADCC_BIT_GO] == busy)
        else $error("go bit differs from busy state");
    AST_FINISH_CLEARS_GO: assert property (@(posedge clk_sys) disable iff (!rstn)
        finish |=> !control_r[ADCC_BIT_GO] && events_r[ADCC_BIT_EV_DONE])
        else $error("finish did not clear go or set done");
    AST_RC_DELAY: assert property (@(posedge clk_sys) disable iff (!rstn)
        (start && rc_selected) |=> state_r == ADCC_ST_DELAY [*3] ##1 state_r == ADCC_ST_DELAY)
        else $error("rc start not held an instruction cycle");
    AST_NONRC_SLEEP_ABORT: assert property (@(posedge clk_sys) disable iff (!rstn)
        (busy && sleep_active && !rc_selected) |=> !busy)
        else $error("sleep did not abort non-rc conversion");
    AST_SLEEP_OFF_KEEPS_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
        (sleep_rise && !rc_selected && conv_on && !wr_control) |=>
            conv_on && !analog_ctl.powered)
        else $error("sleep power down wrong");
    AST_TRIG_START: assert property (@(posedge clk_sys) disable iff (!rstn)
        (trig_match && conv_on && !busy && !sleep_active && !wr_control) |=>
            control_r[ADCC_BIT_GO] && timer_one_clear)
        else $error("trigger did not start");
    AST_TRIG_IGNORED: assert property (@(posedge clk_sys) disable iff (!rstn)
        (trig_match && !conv_on && !busy && !wr_control) |=> !busy && timer_one_clear)
        else $error("trigger handled with converter off");
    AST_GO_NEEDS_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
        (wr_control && !bus_req.wdata[ADCC_BIT_ON] && !busy) |=> !busy)
        else $error("conversion started while off");
    AST_WAKE_VECTOR: assert property (@(posedge clk_sys) disable iff (!rstn)
        (finish && sleep_active && irq_path_on) |=>
            wake_request && vector_jump == $past(global_irq_enable))
        else $error("wake or vector wrong");
    AST_DONE_STICKY: assert property (@(posedge clk_sys) disable iff (!rstn)
        (events_r[ADCC_BIT_EV_DONE] && !(wr_irq_clr && bus_req.wdata[ADCC_BIT_EV_DONE])) |=>
            events_r[ADCC_BIT_EV_DONE])
        else $error("done flag lost");
    AST_CONV_LENGTH: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_r == ADCC_ST_SAMPLE && state_nxt == ADCC_ST_CONVERT) |=> bit_idx_r == 4'h9)
        else $error("conversion does not begin at bit nine");
endmodule
`default_nettype wire

// ### verification/adcc_analog_model.sv
// partner: analog input level and comparator facing the converter
`default_nettype none
module adcc_analog_model
    import adcc_pkg::*;
(
    // converter side
    input wire adcc_pkg::adcc_analog_t analog_ctl,
    output logic comparator_in,
    // level under test
    input wire logic [9:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // ten-bit compare
    // powered off: output follows a changing bit so a stale answer never looks valid
    assign comparator_in = analog_ctl.powered ? (level >= analog_ctl.trial_code)
                                              : ~analog_ctl.trial_code[0];
endmodule
`default_nettype wire

// ### verification/tb_adc_conversion_control.sv
// testbench: register-level scenarios for the converter control
`default_nettype none
module tb_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ns;
    import adcc_pkg::*;
    // ****
    // signals
    // ****
    logic clk_sys = 1'b0;
    logic rstn, sleep_active, global_irq_enable, peripheral_irq_enable, compare_trigger;
    logic rc_clock_in, comparator_in, timer_one_clear, wake_request, vector_jump, irq;
    logic [3:0] compare_mode_select;
    logic [12:0] vector_addr;
    logic [11:0] analog_select;
    logic [9:0] level;
    logic [7:0] bus_rdata, d;
    adcc_bus_req_t bus_req;
    adcc_analog_t analog_ctl;
    int err_count = 0, check_count = 0, cyc = 0, tclr_cnt = 0, wake_cnt = 0, vec_cnt = 0, t0;
    int divs[6] = '{2, 8, 32, 4, 16, 64};
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    adcc_conversion_control dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .sleep_active(sleep_active),
        .global_irq_enable(global_irq_enable), .peripheral_irq_enable(peripheral_irq_enable),
        .compare_mode_select(compare_mode_select), .compare_trigger(compare_trigger),
        .timer_one_clear(timer_one_clear), .wake_request(wake_request),
        .vector_jump(vector_jump), .vector_addr(vector_addr), .irq(irq),
        .comparator_in(comparator_in), .rc_clock_in(rc_clock_in), .analog_ctl(analog_ctl),
        .analog_select(analog_select));
    adcc_analog_model analog (.analog_ctl(analog_ctl), .comparator_in(comparator_in),
        .level(level));
    initial forever #25 clk_sys = ~clk_sys;
    // free-running rc oscillator, 500 khz, its edges land on clk_sys falling edges
    initial begin
        rc_clock_in = 1'b0;
        forever #1000 rc_clock_in = ~rc_clock_in;
    end
    // pulses are one cycle wide, so they are counted rather than polled
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        tclr_cnt <= tclr_cnt + int'(timer_one_clear === 1'b1);
        wake_cnt <= wake_cnt + int'(wake_request === 1'b1);
        vec_cnt <= vec_cnt + int'(vector_jump === 1'b1);
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    // ****
    // tasks
    // ****
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        @(negedge clk_sys);
        v = bus_rdata;
    endtask
    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        rd(a, d);
        check(16'(d), 16'(e));
    endtask
    task automatic wait_idle();
        d = 8'hff;
        for (int i = 0; i < 400 && d[ADCC_BIT_GO] !== 1'b0; i++) rd(ADCC_OFS_CONTROL, d);
        check(16'(d[ADCC_BIT_GO]), 16'h0000);
    endtask
    task automatic trig();
        @(posedge clk_sys);
        compare_trigger <= 1'b1;
        @(posedge clk_sys);
        compare_trigger <= 1'b0;
    endtask
    task automatic set_sleep(input logic v);
        @(posedge clk_sys);
        sleep_active <= v;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    initial begin
        bus_req = '0;
        rstn = 1'b0;
        sleep_active = 1'b0;
        global_irq_enable = 1'b0;
        peripheral_irq_enable = 1'b0;
        compare_trigger = 1'b0;
        compare_mode_select = 4'h0;
        level = 10'h2a5;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(ADCC_OFS_CONTROL, 8'h00);
        rdc(ADCC_OFS_CLOCK_CFG, 8'h00);
        rdc(ADCC_OFS_ANALOG_SELECT_LOW_LOW, 8'hff);
        rdc(ADCC_OFS_ANALOG_SELECT_LOW_HIGH, 8'h0f);
        rdc(9'h1a0, 8'h00);
        check(16'(analog_select), 16'h0fff);
        wr(ADCC_OFS_CONTROL, 8'h02);
        rdc(ADCC_OFS_CONTROL, 8'h00);
        wr(ADCC_OFS_IRQ_ENABLE, 8'h01);
        foreach (divs[i]) begin
            wr(ADCC_OFS_CLOCK_CFG, {1'b0, codes[i], 4'h0});
            rdc(ADCC_OFS_CLOCK_CFG, {1'b0, codes[i], 4'h0});
            // level fixed, reads give the gap, start by go bit
            wr(ADCC_OFS_CONTROL, 8'h83);
            t0 = cyc;
            wait_idle();
            check(16'(cyc - t0 >= 11 * divs[i] - 1 && cyc - t0 <= 11 * divs[i] + 8), 16'h1);
            rdc(ADCC_OFS_RESULT_HIGH, 8'h02);
            rdc(ADCC_OFS_RESULT_LOW, 8'ha5);
        end
        check(16'(irq), 16'h1);
        rdc(ADCC_OFS_IRQ_STATUS, 8'h01);
        wr(ADCC_OFS_IRQ_CLEAR, 8'h01);
        @(negedge clk_sys);
        check(16'(irq), 16'h0);
        wr(ADCC_OFS_CLOCK_CFG, 8'h00);
        wr(ADCC_OFS_CONTROL, 8'h03);
        wait_idle();
        rdc(ADCC_OFS_RESULT_HIGH, 8'ha9);
        rdc(ADCC_OFS_RESULT_LOW, 8'h40);
        compare_mode_select <= ADCC_TRIG_MODE;
        wr(ADCC_OFS_CONTROL, 8'h01);
        trig();
        rdc(ADCC_OFS_CONTROL, 8'h03);
        check(16'(tclr_cnt), 16'h1);
        wait_idle();
        wr(ADCC_OFS_CONTROL, 8'h00);
        trig();
        rdc(ADCC_OFS_CONTROL, 8'h00);
        check(16'(tclr_cnt), 16'h2);
        compare_mode_select <= 4'ha;
        wr(ADCC_OFS_CONTROL, 8'h01);
        trig();
        rdc(ADCC_OFS_CONTROL, 8'h01);
        check(16'(tclr_cnt), 16'h2);
        wr(ADCC_OFS_IRQ_CLEAR, 8'h03);
        wr(ADCC_OFS_CLOCK_CFG, 8'h60);
        wr(ADCC_OFS_CONTROL, 8'h83);
        sleep_active <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdc(ADCC_OFS_CONTROL, 8'h81);
        check(16'(analog_ctl.powered), 16'h0);
        rdc(ADCC_OFS_IRQ_STATUS, 8'h02);
        set_sleep(1'b0);
        wr(ADCC_OFS_IRQ_CLEAR, 8'h03);
        peripheral_irq_enable <= 1'b1;
        global_irq_enable <= 1'b1;
        wr(ADCC_OFS_CLOCK_CFG, 8'h70);
        rdc(ADCC_OFS_CLOCK_CFG, 8'h70);
        wr(ADCC_OFS_CONTROL, 8'h83);
        sleep_active <= 1'b1;
        wait_idle();
        rdc(ADCC_OFS_RESULT_LOW, 8'ha5);
        check(16'(wake_cnt), 16'h1);
        check(16'(vec_cnt), 16'h1);
        check(16'(vector_addr), 16'h0004);
        set_sleep(1'b0);
        wr(ADCC_OFS_IRQ_ENABLE, 8'h00);
        wr(ADCC_OFS_CLOCK_CFG, 8'h30);
        wr(ADCC_OFS_CONTROL, 8'h83);
        sleep_active <= 1'b1;
        wait_idle();
        check(16'(analog_ctl.powered), 16'h0);
        rdc(ADCC_OFS_CONTROL, 8'h81);
        check(16'(wake_cnt), 16'h1);
        set_sleep(1'b0);
        // reset lands mid-conversion; the stored result must survive it
        wr(ADCC_OFS_CLOCK_CFG, 8'h60);
        wr(ADCC_OFS_CONTROL, 8'h83);
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rdc(ADCC_OFS_CONTROL, 8'h00);
        rdc(ADCC_OFS_RESULT_HIGH, 8'h02);
        rdc(ADCC_OFS_RESULT_LOW, 8'ha5);
        check(16'(analog_ctl.powered), 16'h0);
        wr(ADCC_OFS_CONTROL, 8'h83);
        wait_idle();
        check(16'(irq), 16'h0);
        rdc(ADCC_OFS_IRQ_STATUS, 8'h01);
        wr(ADCC_OFS_IRQ_ENABLE, 8'h01);
        @(negedge clk_sys);
        check(16'(irq), 16'h1);
        wr(ADCC_OFS_IRQ_CLEAR, 8'h01);
        @(negedge clk_sys);
        check(16'(irq), 16'h0);
        complete_run();
    end
endmodule
`default_nettype wire
